// File: sadc_sequencer.v
// Sequencer for a 10-bit successive approximation converter: mode and
// channel registers, pin qualification, sampling, bit search, results.
// Assumes a register port on the same clock, port configuration from
// same-clock registers, and a comparator output from the analog side.
//
// Function
// - Convert only analog, input-direction, selected pins
// - Differential selection excludes pin from this converter
// - Enable bit powers the comparator
// - Mode bits six to one set conversion time
// - Three-bit code selects one of eight inputs
// - Writing start bit begins conversion
// - Sample two steps, then hold until end
// - Search starts with bit nine, half tap
// - Next lower bit set, tap from decided bits
// - Keep one when input at least tap
// - After ten bits, store results, raise interrupt
// - Word is value times 64; byte eight bits
// - Conversions repeat until start bit cleared
// - Channel write restarts conversion from beginning
// - Clearing start stops at once, results kept
// - Reset clears both result registers
// - After channel write, one full conversion time
// - Read beats simultaneous result write; write follows
// - Config write at end suppresses result, interrupt
// - Channel change leaves end flag untouched
`timescale 1ns/1ps

module sadc_sequencer #(
  parameter HAS_DIFF = 1 // Variant with a second converter sharing pins
) (
  input wire MCLK_IN,
  input wire NRST_IN,
  input wire REG_WR_IN,
  input wire REG_RD_IN,
  input wire [1:0] REG_SEL_IN,
  input wire [7:0] REG_WDATA_IN,
  output reg [15:0] REG_RDATA_OUT,
  input wire [3:0] ANALOG_PIN_COUNT_IN,
  input wire PIN_CFG_WR_IN,
  input wire [7:0] PORT_DIRECTION_IN,
  input wire [7:0] DIFF_PAIR_SEL_IN,
  input wire CMP_HIGH_IN,
  input wire FLAG_CLR_IN,
  output reg CMP_ENABLE_OUT,
  output reg SAMPLE_OUT,
  output reg CONVERTING_OUT,
  output reg [2:0] CHANNEL_OUT,
  output wire CHANNEL_OK_OUT,
  output reg [9:0] TAP_CODE_OUT,
  output reg CONV_END_IRQ_OUT,
  output reg CONV_END_FLAG_OUT
);

`include "sadc_consts.vh"

// One-hot sequencer states
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_SAMPLE = 3'b010;
localparam [2:0] ST_CONV = 3'b100;

reg [2:0] state_reg; // Sequencer state
reg [2:0] state_next;
reg [7:0] mode_reg; // converter_mode_control
reg [7:0] mode_next;
reg [7:0] chan_reg; // input_channel_select
reg [7:0] chan_next;
reg [15:0] word_reg; // result_word
reg [15:0] word_next;
reg [7:0] byte_reg; // result_byte
reg [7:0] byte_next;
reg [9:0] sar_reg; // Approximation register
reg [9:0] sar_next;
reg [3:0] idx_reg; // Bit under trial
reg [3:0] idx_next;
reg [1:0] samp_reg; // Sample steps remaining
reg [1:0] samp_next;
reg [9:0] pend_val_reg; // Result held back by a colliding read
reg [9:0] pend_val_next;
reg pend_reg; // A held-back result awaits storing
reg pend_next;
reg irq_next;
reg flag_next;
reg restart; // Reload the step timer
reg cmp_meta_reg; // First synchroniser stage
reg cmp_sync_reg; // Comparator decision, safe to use
wire tick; // End of a sample or bit step
wire [7:0] analog_pin; // Pin configured as analog
wire [7:0] chan_ok; // Pin may feed this converter
wire start_bit;
wire [2:0] chan_code;
wire [6:0] step_len;
wire mode_wr;
wire chan_wr;
wire cfg_wr;
wire res_rd;
wire [9:0] final_val;

assign start_bit = mode_reg[`SADC_START_BIT];
assign chan_code = chan_reg[`SADC_CHAN_HI:`SADC_CHAN_LO];
// Conversion time code widened onto the floor
assign step_len = {1'b0, mode_reg[`SADC_TIME_HI:`SADC_TIME_LO]} +
  `SADC_STEP_MIN;
assign mode_wr = REG_WR_IN && (REG_SEL_IN == `SADC_SEL_MODE);
assign chan_wr = REG_WR_IN && (REG_SEL_IN == `SADC_SEL_CHAN);
assign cfg_wr = mode_wr || chan_wr || PIN_CFG_WR_IN;
assign res_rd = REG_RD_IN &&
  ((REG_SEL_IN == `SADC_SEL_WORD) || (REG_SEL_IN == `SADC_SEL_BYTE));
// Last decision folded in: keep bit 0 only if input reaches the tap
assign final_val = {sar_reg[9:1], sar_reg[0] & cmp_sync_reg};

////////////////////////////////////////////////////////////////////////
// Pin qualification, one slice per analog pin
genvar gi;
generate
  for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
    // Count code n turns the n lowest pins digital; 8 means all
    assign analog_pin[gi] = (ANALOG_PIN_COUNT_IN <= gi) &&
      (ANALOG_PIN_COUNT_IN <= `SADC_ALL_DIGITAL);
    if (HAS_DIFF != 0) begin : g_ds
      // Output direction or differential claim blocks conversion
      assign chan_ok[gi] = analog_pin[gi] && PORT_DIRECTION_IN[gi] &&
        !DIFF_PAIR_SEL_IN[gi];
    end else begin : g_nods
      assign chan_ok[gi] = analog_pin[gi] &&
        PORT_DIRECTION_IN[gi];
    end
  end
endgenerate

assign CHANNEL_OK_OUT = chan_ok[chan_code];

////////////////////////////////////////////////////////////////////////
// Step pacing; one tick per sample step or bit decision
sadc_step_timer u_timer (
  .clk_in(MCLK_IN),
  .rst_n_in(NRST_IN),
  .restart_in(restart),
  .len_in(step_len),
  .tick_out(tick)
);

////////////////////////////////////////////////////////////////////////
// Comparator crossing: analog decision is asynchronous to our clock.
// Step floor of four cycles leaves it settled before each tick.
always @(posedge MCLK_IN) begin
  if (!NRST_IN) begin
    cmp_meta_reg <= 1'b0;
    cmp_sync_reg <= 1'b0;
  end else begin
    cmp_meta_reg <= CMP_HIGH_IN;
    cmp_sync_reg <= cmp_meta_reg;
  end
end

////////////////////////////////////////////////////////////////////////
// Sequencer, search and result storage
always @* begin
  state_next = state_reg;
  mode_next = mode_reg;
  chan_next = chan_reg;
  word_next = word_reg;
  byte_next = byte_reg;
  sar_next = sar_reg;
  idx_next = idx_reg;
  samp_next = samp_reg;
  pend_val_next = pend_val_reg;
  pend_next = pend_reg;
  irq_next = 1'b0;
  flag_next = CONV_END_FLAG_OUT;
  restart = 1'b0;

  // Register writes; software keeps channel bits 3..7 at zero
  if (mode_wr) begin
    mode_next = REG_WDATA_IN;
  end
  if (chan_wr) begin
    chan_next = REG_WDATA_IN;
  end

  case (state_reg)
    ST_IDLE: begin
      // Begin when start set and the selected pin qualifies
      if (start_bit && CHANNEL_OK_OUT && !cfg_wr) begin
        state_next = ST_SAMPLE;
        samp_next = `SADC_SAMPLE_STEPS;
        restart = 1'b1;
      end
    end
    ST_SAMPLE: begin
      if (tick) begin
        if (samp_reg == `SADC_STEPS_ONE) begin
          // Sampling done: hold and start the search at the MSB
          state_next = ST_CONV;
          sar_next = `SADC_SAR_MSB_ONLY;
          idx_next = `SADC_IDX_MSB;
        end else begin
          samp_next = samp_reg - `SADC_STEPS_ONE;
        end
      end
    end
    ST_CONV: begin
      if (tick) begin
        if (idx_reg == `SADC_IDX_ZERO) begin
          // Ten bits decided; store unless a config write collides
          if (!cfg_wr) begin
            irq_next = 1'b1;
            flag_next = 1'b1;
            if (res_rd) begin
              pend_next = 1'b1;
              pend_val_next = final_val;
            end else begin
              word_next = {final_val, `SADC_WORD_PAD};
              byte_next = final_val[`SADC_MSB:`SADC_BYTE_LO];
            end
          end
          // Back-to-back conversion
          state_next = ST_SAMPLE;
          samp_next = `SADC_SAMPLE_STEPS;
        end else begin
          // Drop the trial bit if input is below the tap
          if (!cmp_sync_reg) begin
            sar_next[idx_reg] = 1'b0;
          end
          // Next lower trial bit; tap follows decided bits
          sar_next[idx_reg - `SADC_IDX_ONE] = 1'b1;
          idx_next = idx_reg - `SADC_IDX_ONE;
        end
      end
    end
    default: begin
      state_next = ST_IDLE;
    end
  endcase

  // Abort on stop, lost qualification or channel rewrite
  if (state_reg != ST_IDLE) begin
    if (mode_wr && !REG_WDATA_IN[`SADC_START_BIT]) begin
      state_next = ST_IDLE;
    end else if (!CHANNEL_OK_OUT) begin
      state_next = ST_IDLE;
    end else if (chan_wr) begin
      // Full conversion time from the write to the next end
      state_next = ST_IDLE;
    end
  end

  // Held-back result lands once no read is colliding
  if (pend_reg && !res_rd) begin
    word_next = {pend_val_reg, `SADC_WORD_PAD};
    byte_next = pend_val_reg[`SADC_MSB:`SADC_BYTE_LO];
    pend_next = 1'b0;
  end

  // Channel writes never touch the flag; hardware set beats clear
  if (FLAG_CLR_IN && !irq_next) begin
    flag_next = 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////
// State registers
always @(posedge MCLK_IN) begin
  if (!NRST_IN) begin
    state_reg <= ST_IDLE;
    mode_reg <= `SADC_MODE_RST;
    chan_reg <= `SADC_CHAN_RST;
    word_reg <= `SADC_WORD_RST;
    byte_reg <= `SADC_BYTE_RST;
    sar_reg <= `SADC_SAR_RST;
    idx_reg <= `SADC_IDX_ZERO;
    samp_reg <= `SADC_STEPS_ZERO;
    pend_val_reg <= `SADC_SAR_RST;
    pend_reg <= 1'b0;
    CONV_END_IRQ_OUT <= 1'b0;
    CONV_END_FLAG_OUT <= 1'b0;
  end else begin
    state_reg <= state_next;
    mode_reg <= mode_next;
    chan_reg <= chan_next;
    word_reg <= word_next;
    byte_reg <= byte_next;
    sar_reg <= sar_next;
    idx_reg <= idx_next;
    samp_reg <= samp_next;
    pend_val_reg <= pend_val_next;
    pend_reg <= pend_next;
    CONV_END_IRQ_OUT <= irq_next;
    CONV_END_FLAG_OUT <= flag_next;
  end
end

////////////////////////////////////////////////////////////////////////
// Analog front-end controls, all registered
always @(posedge MCLK_IN) begin
  if (!NRST_IN) begin
    CMP_ENABLE_OUT <= 1'b0;
    SAMPLE_OUT <= 1'b0;
    CONVERTING_OUT <= 1'b0;
    CHANNEL_OUT <= 3'h0;
    TAP_CODE_OUT <= `SADC_SAR_RST;
  end else begin
    CMP_ENABLE_OUT <= mode_next[`SADC_CMPEN_BIT];
    // Switch closed only while sampling; open means hold
    SAMPLE_OUT <= (state_next == ST_SAMPLE);
    CONVERTING_OUT <= (state_next != ST_IDLE);
    CHANNEL_OUT <= chan_next[`SADC_CHAN_HI:`SADC_CHAN_LO];
    TAP_CODE_OUT <= sar_next;
  end
end

////////////////////////////////////////////////////////////////////////
// Read port; data sampled before any same-edge result update
always @(posedge MCLK_IN) begin
  if (!NRST_IN) begin
    REG_RDATA_OUT <= `SADC_WORD_RST;
  end else if (REG_RD_IN) begin
    if (REG_SEL_IN == `SADC_SEL_MODE) begin
      REG_RDATA_OUT <= {8'h00, mode_reg};
    end else if (REG_SEL_IN == `SADC_SEL_CHAN) begin
      REG_RDATA_OUT <= {8'h00, chan_reg};
    end else if (REG_SEL_IN == `SADC_SEL_WORD) begin
      REG_RDATA_OUT <= word_reg;
    end else begin
      REG_RDATA_OUT <= {8'h00, byte_reg};
    end
  end
end

endmodule // sadc_sequencer

// File: sadc_consts.vh
// Constants for the successive approximation converter sequencer.
// Assumes inclusion by bare name from each design file that needs them.
`ifndef SADC_CONSTS_VH
`define SADC_CONSTS_VH

// Register select codes on the internal register port
`define SADC_SEL_MODE 2'h0
`define SADC_SEL_CHAN 2'h1
`define SADC_SEL_WORD 2'h2
`define SADC_SEL_BYTE 2'h3

// Mode register fields
`define SADC_CMPEN_BIT 0
`define SADC_START_BIT 7
`define SADC_TIME_HI 6
`define SADC_TIME_LO 1

// Channel register fields
`define SADC_CHAN_HI 2
`define SADC_CHAN_LO 0

// Reset values
`define SADC_MODE_RST 8'h00
`define SADC_CHAN_RST 8'h00
`define SADC_WORD_RST 16'h0000
`define SADC_BYTE_RST 8'h00
`define SADC_SAR_RST 10'h000

// Approximation register layout
`define SADC_MSB 9
`define SADC_SAR_MSB_ONLY 10'h200
`define SADC_IDX_MSB 4'h9
`define SADC_IDX_ZERO 4'h0
`define SADC_IDX_ONE 4'h1

// Result alignment: word is value times 64, byte is top eight bits
`define SADC_WORD_PAD 6'h00
`define SADC_BYTE_LO 2

// Analog pin count code that makes every pin digital
`define SADC_ALL_DIGITAL 4'h8

// Timing: a step lasts the conversion time code plus a floor,
// the floor covering the comparator synchroniser latency
`define SADC_STEP_MIN 7'h04
`define SADC_SAMPLE_STEPS 2'h2
`define SADC_STEPS_ONE 2'h1
`define SADC_STEPS_ZERO 2'h0
`define SADC_CNT_ONE 7'h01
`define SADC_CNT_ZERO 7'h00

`endif

// File: sadc_step_timer.v
// Step timer that paces sampling and each bit decision.
// Assumes the sequencer clock and its synchronous active-low reset.
`timescale 1ns/1ps

module sadc_step_timer (
  input wire clk_in,
  input wire rst_n_in,
  input wire restart_in,
  input wire [6:0] len_in,
  output reg tick_out
);

`include "sadc_consts.vh"

reg [6:0] count_reg; // Cycles left in the current step
reg [6:0] count_next;
reg tick_next;

////////////////////////////////////////////////////////////////////////
// Down counter, reloaded on restart and at every step end
always @* begin
  count_next = count_reg;
  tick_next = 1'b0;
  if (restart_in) begin
    // Fresh step; length sampled now, so time changes apply next step
    count_next = len_in - `SADC_CNT_ONE;
  end else if (count_reg == `SADC_CNT_ZERO) begin
    tick_next = 1'b1;
    count_next = len_in - `SADC_CNT_ONE;
  end else begin
    count_next = count_reg - `SADC_CNT_ONE;
  end
end

////////////////////////////////////////////////////////////////////////
// State flops
always @(posedge clk_in) begin
  if (!rst_n_in) begin
    count_reg <= `SADC_CNT_ZERO;
    tick_out <= 1'b0;
  end else begin
    count_reg <= count_next;
    tick_out <= tick_next;
  end
end

endmodule // sadc_step_timer

// File: sadc_afe_model.sv
// Behavioural analog front end: sample-hold, tap and comparator.
// Assumes the sequencer clock; levels are ten-bit codes per input.
`timescale 1ns/1ps

module sadc_afe_model (
  input wire clk_in,
  input wire enable_in,
  input wire sample_in,
  input wire [2:0] channel_in,
  input wire [9:0] tap_in,
  input wire [79:0] levels_in,
  output reg cmp_high_out
);
  reg [9:0] held_reg; // Voltage kept on the hold capacitor

  //////////////////////////////////////////////////////////////////////
  // Track while sampling, keep while holding
  always @(posedge clk_in) begin
    if (sample_in) begin
      held_reg <= levels_in[channel_in*10 +: 10];
    end
  end

  // Unpowered comparator gives a toggling, useless answer
  always @(posedge clk_in) begin
    if (!enable_in) begin
      cmp_high_out <= ~cmp_high_out;
    end else begin
      cmp_high_out <= (held_reg >= tap_in);
    end
  end

  initial cmp_high_out = 1'b0;
endmodule // sadc_afe_model

// File: sadc_properties.sv
// Checker for the converter sequencer, watching only its top ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps

module sadc_properties (
  input wire MCLK_IN,
  input wire NRST_IN,
  input wire REG_WR_IN,
  input wire REG_RD_IN,
  input wire [1:0] REG_SEL_IN,
  input wire [7:0] REG_WDATA_IN,
  input wire [15:0] REG_RDATA_OUT,
  input wire [3:0] ANALOG_PIN_COUNT_IN,
  input wire PIN_CFG_WR_IN,
  input wire [7:0] PORT_DIRECTION_IN,
  input wire [7:0] DIFF_PAIR_SEL_IN,
  input wire FLAG_CLR_IN,
  input wire CMP_ENABLE_OUT,
  input wire SAMPLE_OUT,
  input wire CONVERTING_OUT,
  input wire [2:0] CHANNEL_OUT,
  input wire CHANNEL_OK_OUT,
  input wire [9:0] TAP_CODE_OUT,
  input wire CONV_END_IRQ_OUT,
  input wire CONV_END_FLAG_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!NRST_IN);

  wire mode_wr = REG_WR_IN && (REG_SEL_IN == 2'h0); // Mode write seen

  //////////////////////////////////////////////////////////////////////
  // Enable bit reaches the comparator
  a_cmp_enable_follow: assert property (mode_wr |=>
    (CMP_ENABLE_OUT == $past(REG_WDATA_IN[0]))) else $error("enable mismatch");
  // Clearing start stops at once
  a_stop_at_once: assert property (mode_wr && !REG_WDATA_IN[7]
    |-> ##[1:2] !CONVERTING_OUT) else $error("did not stop");
  // Search opens with bit nine alone, then holds
  a_msb_first: assert property ($fell(SAMPLE_OUT) && CONVERTING_OUT
    |-> TAP_CODE_OUT == 10'h200) else $error("first trial wrong");
  // Hold ends only at a conversion end, after idle or on a write
  a_hold_kept: assert property ($rose(SAMPLE_OUT) |-> CONV_END_IRQ_OUT ||
    !$past(CONVERTING_OUT) || $past(REG_WR_IN) || $past(PIN_CFG_WR_IN))
    else $error("hold cut short");
  // End pulse lasts one cycle and sets the flag
  a_irq_single: assert property (CONV_END_IRQ_OUT
    |=> !CONV_END_IRQ_OUT) else $error("irq too long");
  a_irq_flag: assert property (CONV_END_IRQ_OUT
    |-> CONV_END_FLAG_OUT) else $error("flag not set");
  // Only an explicit clear drops the flag
  a_flag_sticky: assert property (CONV_END_FLAG_OUT && !FLAG_CLR_IN
    |=> CONV_END_FLAG_OUT) else $error("flag lost");
  // Pin qualification from config, direction and claim
  a_pin_qualify: assert property (CHANNEL_OK_OUT ==
    (({1'b0, CHANNEL_OUT} >= ANALOG_PIN_COUNT_IN) &&
    PORT_DIRECTION_IN[CHANNEL_OUT] && !DIFF_PAIR_SEL_IN[CHANNEL_OUT]))
    else $error("qualification wrong");
  // Read data is kept between reads
  a_rdata_stable: assert property (!REG_RD_IN
    |=> $stable(REG_RDATA_OUT)) else $error("read data moved");
  // Reset clears data and activity; checked during reset itself
  a_reset_clear: assert property (disable iff (1'b0) !NRST_IN
    |=> (REG_RDATA_OUT == 16'h0000) && !CONVERTING_OUT)
    else $error("reset not clean");

  c_conv_end: cover property (CONV_END_IRQ_OUT);
  c_hold_start: cover property ($fell(SAMPLE_OUT) && CONVERTING_OUT);
  c_chan_restart: cover property (REG_WR_IN && REG_SEL_IN == 2'h1 &&
    CONVERTING_OUT);
endmodule // sadc_properties

bind sadc_sequencer sadc_properties u_props (
  .MCLK_IN(MCLK_IN), .NRST_IN(NRST_IN), .REG_WR_IN(REG_WR_IN),
  .REG_RD_IN(REG_RD_IN), .REG_SEL_IN(REG_SEL_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .ANALOG_PIN_COUNT_IN(ANALOG_PIN_COUNT_IN),
  .PIN_CFG_WR_IN(PIN_CFG_WR_IN),
  .PORT_DIRECTION_IN(PORT_DIRECTION_IN),
  .DIFF_PAIR_SEL_IN(DIFF_PAIR_SEL_IN), .FLAG_CLR_IN(FLAG_CLR_IN),
  .CMP_ENABLE_OUT(CMP_ENABLE_OUT), .SAMPLE_OUT(SAMPLE_OUT),
  .CONVERTING_OUT(CONVERTING_OUT), .CHANNEL_OUT(CHANNEL_OUT),
  .CHANNEL_OK_OUT(CHANNEL_OK_OUT), .TAP_CODE_OUT(TAP_CODE_OUT),
  .CONV_END_IRQ_OUT(CONV_END_IRQ_OUT),
  .CONV_END_FLAG_OUT(CONV_END_FLAG_OUT));

// File: tb_top.sv
// Self-checking bench: register tasks drive the sequencer, the analog
// model answers. Assumes the 200 MHz clock and four reset cycles.
`timescale 1ns/1ps

module tb_top;
  reg mclk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, fclr = 1'b0;
  reg pcfg = 1'b0; // Port-configuration write pulse
  reg [1:0] sel = 2'h0;
  reg [7:0] wdat = 8'h00, dir = 8'hFF, diff = 8'h00;
  reg [3:0] cnt_code = 4'h0; // Every pin analog
  // Ten-bit levels, input zero in the low bits; includes end codes
  reg [79:0] lv = {10'h3FE, 10'h001, 10'h2AA, 10'h155,
                   10'h1FF, 10'h200, 10'h000, 10'h3FF};
  wire [15:0] rdata;
  wire [9:0] tap;
  wire [2:0] chan;
  wire cmp, cen, smp, conv, ok, irq, flag;
  integer num_errors = 0, samples_checked = 0, cyc = 0, n, ch;
  reg [15:0] d;

  initial forever #2.5 mclk = ~mclk; // 5 ns period

  sadc_sequencer DUT (.MCLK_IN(mclk), .NRST_IN(nrst), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_SEL_IN(sel), .REG_WDATA_IN(wdat),
    .REG_RDATA_OUT(rdata), .ANALOG_PIN_COUNT_IN(cnt_code),
    .PIN_CFG_WR_IN(pcfg), .PORT_DIRECTION_IN(dir),
    .DIFF_PAIR_SEL_IN(diff), .CMP_HIGH_IN(cmp), .FLAG_CLR_IN(fclr),
    .CMP_ENABLE_OUT(cen), .SAMPLE_OUT(smp), .CONVERTING_OUT(conv),
    .CHANNEL_OUT(chan), .CHANNEL_OK_OUT(ok), .TAP_CODE_OUT(tap),
    .CONV_END_IRQ_OUT(irq), .CONV_END_FLAG_OUT(flag));
  sadc_afe_model u_afe (.clk_in(mclk), .enable_in(cen), .sample_in(smp),
    .channel_in(chan), .tap_in(tap), .levels_in(lv), .cmp_high_out(cmp));

  //////////////////////////////////////////////////////////////////////
  // Register write: one-cycle strobe
  task wr_reg(input [1:0] s, input [7:0] v);
    begin
      @(posedge mclk);
      wr <= 1'b1;
      sel <= s;
      wdat <= v;
      @(posedge mclk);
      wr <= 1'b0;
    end
  endtask
  // Register read: data kept until the next read, sampled late
  task rd_reg(input [1:0] s, output [15:0] v);
    begin
      @(posedge mclk);
      rd <= 1'b1;
      sel <= s;
      @(posedge mclk);
      rd <= 1'b0;
      @(posedge mclk);
      #1 v = rdata;
    end
  endtask
  // Count cycles to the end pulse, giving up at the limit
  task wait_irq(input integer lim, output integer c);
    begin
      c = 0;
      #1;
      while (c < lim && irq !== 1'b1) begin
        @(posedge mclk);
        #1 c = c + 1;
      end
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // Hang guard, far above the expected run length
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors = num_errors + 1;
      tally_and_finish;
    end
  end

  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    rd_reg(2'h2, d);
    chk(d, 16'h0000);
    rd_reg(2'h3, d);
    chk(d, 16'h0000);
    // Separate enable step, so no first result needs discarding
    wr_reg(2'h0, 8'h01);
    repeat (200) @(posedge mclk);
    chk(cen, 1'b1);
    wr_reg(2'h0, 8'h81);
    rd_reg(2'h0, d);
    chk(d, 16'h0081);
    // Each input in turn; channel write restarts a full conversion
    for (ch = 0; ch < 8; ch = ch + 1) begin
      wr_reg(2'h1, ch[7:0]);
      wait_irq(400, n);
      chk(n >= 48 && n <= 56, 1'b1);
      rd_reg(2'h2, d);
      chk(d, {lv[ch*10 +: 10], 6'h00});
      rd_reg(2'h3, d);
      chk(d, {8'h00, lv[ch*10+2 +: 8]});
    end
    // Longer time code: step of nine cycles
    wr_reg(2'h0, 8'h8B);
    wr_reg(2'h1, 8'h03);
    wait_irq(400, n);
    chk(n >= 108 && n <= 116, 1'b1);
    @(posedge mclk);
    wait_irq(400, n);
    chk(n >= 100 && n <= 116, 1'b1);
    rd_reg(2'h2, d);
    chk(d, {10'h1FF, 6'h00});
    // Stop in mid conversion: no more results, old one kept
    lv[30 +: 10] <= 10'h0AA;
    repeat (30) @(posedge mclk);
    wr_reg(2'h0, 8'h0B);
    @(posedge mclk);
    #1 chk(conv, 1'b0);
    wait_irq(300, n);
    chk(n, 300);
    rd_reg(2'h2, d);
    chk(d, {10'h1FF, 6'h00});
    // Output direction, claimed pin and digital config all refuse
    dir <= 8'hF7;
    wr_reg(2'h0, 8'h81);
    #1 chk(ok, 1'b0);
    wait_irq(200, n);
    chk(n, 200);
    dir <= 8'hFF;
    diff <= 8'h08;
    @(posedge mclk);
    #1 chk(ok, 1'b0);
    diff <= 8'h00;
    cnt_code <= 4'h4;
    @(posedge mclk);
    #1 chk(ok, 1'b0);
    cnt_code <= 4'h3;
    @(posedge mclk);
    #1 chk(ok, 1'b1);
    wait_irq(400, n);
    chk(n < 400, 1'b1);
    rd_reg(2'h2, d);
    chk(d, {10'h0AA, 6'h00});
    // Port-config write lands in the end cycle of the next conversion,
    // which holds a new level: no result and no end pulse may follow
    lv[30 +: 10] <= 10'h155;
    repeat (44) @(posedge mclk);
    pcfg <= 1'b1;
    @(posedge mclk);
    pcfg <= 1'b0;
    wait_irq(40, n);
    chk(n, 40);
    // Read strobe in the end cycle of the one after: old data first
    repeat (6) @(posedge mclk);
    rd_reg(2'h2, d);
    chk(d, {10'h0AA, 6'h00});
    rd_reg(2'h2, d);
    chk(d, {10'h155, 6'h00});
    // Flag survives a channel write, then clears on request
    wr_reg(2'h1, 8'h00);
    #1 chk(flag, 1'b1);
    fclr <= 1'b1;
    @(posedge mclk);
    fclr <= 1'b0;
    @(posedge mclk);
    #1 chk(flag, 1'b0);
    rd_reg(2'h1, d);
    chk(d, 16'h0000);
    tally_and_finish;
  end
endmodule // tb_top
